// ### cca_pkg.sv
// constants, field layouts and shared types of the counter array
package cca_pkg;

  // register byte addresses
  localparam logic [7:0] REG_CTRL          = 8'h00;
  localparam logic [7:0] REG_MODE          = 8'h01;
  localparam logic [7:0] REG_CNT_LO        = 8'h02;
  localparam logic [7:0] REG_CNT_HI        = 8'h03;
  localparam logic [7:0] REG_IRQ_EN        = 8'h04;
  localparam logic [7:0] REG_MOD_MODE_BASE = 8'h08;
  localparam logic [7:0] REG_MOD_VAL_BASE  = 8'h10;

  localparam int NUM_MODULES = 6;
  localparam int WDT_MODULE  = 5;

  // timebase codes
  localparam logic [2:0] TB_SYS_DIV12 = 3'h0;
  localparam logic [2:0] TB_SYS_DIV4  = 3'h1;
  localparam logic [2:0] TB_TIMER0    = 3'h2;
  localparam logic [2:0] TB_COUNT_PIN = 3'h3;
  localparam logic [2:0] TB_SYS       = 3'h4;
  localparam logic [2:0] TB_XOSC_DIV8 = 3'h5;
  localparam logic [2:0] TB_RTC_DIV8  = 3'h6;

  // divider terminal counts
  localparam logic [3:0] DIV12_LAST = 4'hb;
  localparam logic [1:0] DIV4_LAST  = 2'h3;
  localparam logic [2:0] OSC_LAST   = 3'h7;

  localparam logic [15:0] CNT_MAX   = 16'hffff;
  localparam logic [15:0] CNT_RST   = 16'h0000;

  typedef struct packed {
    logic       idle_suspend;
    logic       wdt_enable;
    logic       counter_overflow_flag;
    logic       reserved;
    logic [2:0] timebase_select;
    logic       overflow_irq_enable;
  } cca_cnt_mode_t;

  typedef struct packed {
    logic wide_pwm_select;
    logic compare_enable;
    logic rising_capture_enable;
    logic falling_capture_enable;
    logic match_enable;
    logic toggle_enable;
    logic pwm_enable;
    logic module_irq_enable;
  } cca_mod_mode_t;

  // watchdog on, sysclk/12, everything else clear
  localparam cca_cnt_mode_t CNT_MODE_RST = '{
    idle_suspend: 1'b0, wdt_enable: 1'b1, counter_overflow_flag: 1'b0,
    reserved: 1'b0, timebase_select: TB_SYS_DIV12,
    overflow_irq_enable: 1'b0};

  localparam cca_mod_mode_t MOD_MODE_RST = '0;

  // forced software timer mode for module 5 under the watchdog
  localparam cca_mod_mode_t WDT_FORCED_MODE = '{
    wide_pwm_select: 1'b0, compare_enable: 1'b1,
    rising_capture_enable: 1'b0, falling_capture_enable: 1'b0,
    match_enable: 1'b1, toggle_enable: 1'b0, pwm_enable: 1'b0,
    module_irq_enable: 1'b0};

endpackage

// ### cca_module.sv
// one capture/compare module of the counter array
`timescale 1ns/1ps
`default_nettype none
module cca_module
  import cca_pkg::*;
(
  input  wire logic          ref_clk_i,
  input  wire logic          srst_i,
  input  wire cca_mod_mode_t mode_i,
  input  wire logic [15:0]   count_i,
  input  wire logic          count_upd_i,
  input  wire logic          wr_lo_i,
  input  wire logic          wr_hi_i,
  input  wire logic [7:0]    wdata_i,
  input  wire logic          line_i,
  output logic [15:0]        value_o,
  output logic               event_o,
  output logic               line_o,
  output logic               line_oe_o
);

  typedef struct packed {
    logic        s1;
    logic        s2;
    logic        s3;
    logic [15:0] value;
    logic        tog;
    logic        prev_hso;
    logic        event_p;
    logic        oe;
  } cca_mod_state_t;

  cca_mod_state_t st;
  cca_mod_state_t nxt;
  logic           cap_mode;
  logic           sw_timer;
  logic           hso;
  logic           freq;
  logic           no_edges;
  logic           rise_edge;
  logic           fall_edge;

  // mode decode straight from the mode bits
  assign no_edges  = ~mode_i.rising_capture_enable
                   & ~mode_i.falling_capture_enable;
  assign cap_mode  = ~mode_i.match_enable & ~mode_i.toggle_enable
                   & ~mode_i.pwm_enable & ~no_edges;
  assign sw_timer  = mode_i.compare_enable & mode_i.match_enable
                   & ~mode_i.toggle_enable & ~mode_i.pwm_enable
                   & no_edges;
  assign hso       = mode_i.compare_enable & mode_i.match_enable
                   & mode_i.toggle_enable & ~mode_i.pwm_enable & no_edges;
  assign freq      = mode_i.compare_enable & mode_i.toggle_enable
                   & mode_i.pwm_enable & no_edges;
  // edges seen on the second and third stage only
  assign rise_edge = st.s2 & ~st.s3;
  assign fall_edge = ~st.s2 & st.s3;

  // next state: writes first, hardware events override them
  always_comb begin
    nxt         = st;
    nxt.s1      = line_i;
    nxt.s2      = st.s1;
    nxt.s3      = st.s2;                  // two-cycle levels always survive
    nxt.event_p = 1'b0;
    if (wr_lo_i) begin
      nxt.value[7:0] = wdata_i;
    end
    if (wr_hi_i) begin
      nxt.value[15:8] = wdata_i;
    end
    if (cap_mode && ((mode_i.rising_capture_enable && rise_edge) ||
                     (mode_i.falling_capture_enable && fall_edge))) begin
      nxt.value   = count_i;
      nxt.event_p = 1'b1;
    end
    if ((sw_timer || hso) && count_upd_i && count_i == st.value) begin
      nxt.event_p = 1'b1;
      if (hso) begin
        nxt.tog = ~st.tog;
      end
    end
    // high byte acts as half period; byte add wraps so zero gives 256
    if (freq && count_upd_i && count_i[7:0] == st.value[7:0]) begin
      nxt.tog        = ~st.tog;
      nxt.value[7:0] = st.value[7:0] + st.value[15:8];
    end
    if (hso && !st.prev_hso) begin
      nxt.tog = 1'b1;
    end
    nxt.prev_hso = hso;
    nxt.oe       = hso | freq;
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st       <= '0;
      st.tog   <= 1'b1;
    end else begin
      st <= nxt;
    end
  end

  assign value_o   = st.value;
  assign event_o   = st.event_p;
  assign line_o    = st.tog;
  assign line_oe_o = st.oe;

  cap_copy_a: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    (cap_mode && rise_edge && mode_i.rising_capture_enable)
      |=> (st.value == $past(count_i)) && st.event_p)
    else $error("capture did not copy the counter");

  hso_init_a: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    $rose(st.prev_hso) |-> st.tog)
    else $error("toggle state not one on high-speed entry");

  freq_step_a: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    (freq && count_upd_i && count_i[7:0] == st.value[7:0]
     && !wr_lo_i && !wr_hi_i)
      |=> (st.value[7:0] == $past(st.value[7:0] + st.value[15:8]))
          && (st.tog != $past(st.tog)))
    else $error("frequency output step wrong");

endmodule
`default_nettype wire

// ### cca_top.sv
// counter array: timebase, counter, register port and six modules
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module cca_top
  import cca_pkg::*;
(
  input  wire logic                   ref_clk_i,
  input  wire logic                   srst_i,
  input  wire logic [7:0]             addr_i,
  input  wire logic [7:0]             wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic [7:0]                  rdata_o,
  input  wire logic                   cpu_idle_i,
  input  wire logic                   global_irq_enable_i,
  input  wire logic                   timer0_ovf_i,
  input  wire logic                   external_count_input_i,
  input  wire logic                   ext_osc_i,
  input  wire logic                   rtc_osc_i,
  input  wire logic [NUM_MODULES-1:0] module_io_line_i,
  output logic [NUM_MODULES-1:0]      module_io_line_o,
  output logic [NUM_MODULES-1:0]      module_io_line_oe_o,
  output logic                        irq_o
);

  typedef struct packed {
    logic [15:0]                    cnt;
    logic [7:0]                     snap;
    logic                           run;
    logic [NUM_MODULES-1:0]         flags;
    cca_cnt_mode_t                  mode;
    logic                           arr_ie;
    cca_mod_mode_t [NUM_MODULES-1:0] mmode;
    logic [7:0]                     rdata;
    logic                           irq;
    logic [3:0]                     div12;
    logic [1:0]                     div4;
    logic                           eci_s1;
    logic                           eci_s2;
    logic                           eci_s3;
    logic                           xo_s1;
    logic                           xo_s2;
    logic                           xo_s3;
    logic                           rtc_s1;
    logic                           rtc_s2;
    logic                           rtc_s3;
    logic [2:0]                     xo_div;
    logic [2:0]                     rtc_div;
    logic                           tick_d;
  } cca_top_state_t;

  cca_top_state_t                 st;
  cca_top_state_t                 nxt;
  cca_cnt_mode_t                  wmode;
  cca_mod_mode_t                  eff_mode [NUM_MODULES];
  logic [15:0]                    mod_val  [NUM_MODULES];
  logic [NUM_MODULES-1:0]         mod_event;
  logic [NUM_MODULES-1:0]         mod_ie;
  logic [NUM_MODULES-1:0]         wr_lo;
  logic [NUM_MODULES-1:0]         wr_hi;
  logic [7:0]                     mode_off;
  logic [7:0]                     val_off;
  logic                           mode_hit;
  logic                           val_hit;
  logic [2:0]                     val_idx;
  logic [2:0]                     mode_idx;
  logic                           src;
  logic                           tick;
  logic                           halt;
  logic                           xo_rise;
  logic                           rtc_rise;

  assign wmode    = cca_cnt_mode_t'(wdata_i);
  // module register decode; offsets above the array fall through
  assign mode_off = addr_i - REG_MOD_MODE_BASE;
  assign val_off  = addr_i - REG_MOD_VAL_BASE;
  assign mode_hit = (addr_i >= REG_MOD_MODE_BASE)
                  && (mode_off < 8'(NUM_MODULES));
  assign val_hit  = (addr_i >= REG_MOD_VAL_BASE)
                  && (val_off < 8'(2 * NUM_MODULES));
  assign mode_idx = mode_off[2:0];
  assign val_idx  = val_off[3:1];
  // oscillator edges from the settled stages only
  assign xo_rise  = st.xo_s2 & ~st.xo_s3;
  assign rtc_rise = st.rtc_s2 & ~st.rtc_s3;

  // per-module wiring, watchdog override and write strobes
  for (genvar n = 0; n < NUM_MODULES; n++) begin : g_mod
    assign eff_mode[n] = (n == WDT_MODULE && st.mode.wdt_enable)
                       ? WDT_FORCED_MODE : st.mmode[n];
    assign mod_ie[n]   = st.mmode[n].module_irq_enable;
    assign wr_lo[n]    = wr_i && val_hit && val_idx == 3'(n)
                       && !val_off[0];
    assign wr_hi[n]    = wr_i && val_hit && val_idx == 3'(n)
                       && val_off[0];

    cca_module u_mod (
      .ref_clk_i   (ref_clk_i),
      .srst_i      (srst_i),
      .mode_i      (eff_mode[n]),
      .count_i     (st.cnt),
      .count_upd_i (st.tick_d),
      .wr_lo_i     (wr_lo[n]),
      .wr_hi_i     (wr_hi[n]),
      .wdata_i     (wdata_i),
      .line_i      (module_io_line_i[n]),
      .value_o     (mod_val[n]),
      .event_o     (mod_event[n]),
      .line_o      (module_io_line_o[n]),
      .line_oe_o   (module_io_line_oe_o[n])
    );
  end

  // timebase source select
  always_comb begin
    unique case (st.mode.timebase_select)
      TB_SYS_DIV12: src = (st.div12 == DIV12_LAST);
      TB_SYS_DIV4:  src = (st.div4 == DIV4_LAST);
      TB_TIMER0:    src = timer0_ovf_i;
      TB_COUNT_PIN: src = st.eci_s3 & ~st.eci_s2;
      TB_SYS:       src = 1'b1;
      TB_XOSC_DIV8: src = xo_rise && (st.xo_div == OSC_LAST);
      TB_RTC_DIV8:  src = rtc_rise && (st.rtc_div == OSC_LAST);
      default:      src = 1'b0;
    endcase
  end

  // watchdog forces the counter on; idle halt only when asked for
  assign halt = st.mode.idle_suspend & cpu_idle_i;
  assign tick = src & (st.run | st.mode.wdt_enable) & ~halt;

  // next state of the whole array
  always_comb begin
    nxt        = st;
    nxt.rdata  = '0;
    // prescalers run free so a source switch picks up mid-period
    nxt.div12  = (st.div12 == DIV12_LAST) ? '0 : st.div12 + 4'h1;
    nxt.div4   = st.div4 + 2'h1;
    nxt.eci_s1 = external_count_input_i;
    nxt.eci_s2 = st.eci_s1;
    nxt.eci_s3 = st.eci_s2;
    nxt.xo_s1  = ext_osc_i;
    nxt.xo_s2  = st.xo_s1;
    nxt.xo_s3  = st.xo_s2;
    nxt.rtc_s1 = rtc_osc_i;
    nxt.rtc_s2 = st.rtc_s1;
    nxt.rtc_s3 = st.rtc_s2;
    if (xo_rise) begin
      nxt.xo_div = st.xo_div + 3'h1;
    end
    if (rtc_rise) begin
      nxt.rtc_div = st.rtc_div + 3'h1;
    end

    // register writes
    if (wr_i) begin
      if (addr_i == REG_CTRL) begin
        nxt.run   = wdata_i[NUM_MODULES];
        nxt.flags = st.flags & wdata_i[NUM_MODULES-1:0];
      end
      if (addr_i == REG_MODE) begin
        nxt.mode.overflow_irq_enable   = wmode.overflow_irq_enable;
        nxt.mode.wdt_enable            = wmode.wdt_enable;
        nxt.mode.counter_overflow_flag = st.mode.counter_overflow_flag
                                       & wmode.counter_overflow_flag;
        if (!st.mode.wdt_enable) begin
          nxt.mode.timebase_select = wmode.timebase_select;
          nxt.mode.idle_suspend    = wmode.idle_suspend;
        end
      end
      if (addr_i == REG_CNT_LO && !st.mode.wdt_enable) begin
        nxt.cnt[7:0] = wdata_i;
      end
      if (addr_i == REG_CNT_HI && !st.mode.wdt_enable) begin
        nxt.cnt[15:8] = wdata_i;
      end
      if (addr_i == REG_IRQ_EN) begin
        nxt.arr_ie = wdata_i[0];
      end
      if (mode_hit && !(32'(mode_idx) == WDT_MODULE
                        && st.mode.wdt_enable)) begin
        nxt.mmode[mode_idx] = cca_mod_mode_t'(wdata_i);
      end
      if (val_hit) begin
        // low byte disarms compare, high byte rearms it
        nxt.mmode[val_idx].compare_enable = val_off[0];
      end
    end

    // counting; a tick beats a same-cycle software load
    nxt.tick_d = tick;
    if (tick) begin
      nxt.cnt = st.cnt + 16'h0001;
      if (st.cnt == CNT_MAX) begin
        nxt.mode.counter_overflow_flag = 1'b1;
      end
    end
    // hardware events win over a same-cycle clear
    nxt.flags = nxt.flags | mod_event;

    // register reads, answered in the next cycle
    if (rd_i) begin
      unique case (1'b1)
        addr_i == REG_CTRL:   nxt.rdata = {1'b0, st.run, st.flags};
        addr_i == REG_MODE:   nxt.rdata = st.mode;
        addr_i == REG_CNT_LO: begin
          nxt.rdata = st.cnt[7:0];
          nxt.snap  = st.cnt[15:8];
        end
        addr_i == REG_CNT_HI: nxt.rdata = st.snap;
        addr_i == REG_IRQ_EN: nxt.rdata = {7'h00, st.arr_ie};
        mode_hit:             nxt.rdata = st.mmode[mode_idx];
        val_hit:              nxt.rdata = val_off[0]
                                        ? mod_val[val_idx][15:8]
                                        : mod_val[val_idx][7:0];
        default:              nxt.rdata = '0;
      endcase
    end

    // request gated by both enables
    nxt.irq = global_irq_enable_i & st.arr_ie &
              ((nxt.mode.counter_overflow_flag
                & nxt.mode.overflow_irq_enable)
               | (|(nxt.flags & mod_ie)));
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st       <= '0;
      st.mode  <= CNT_MODE_RST;
      st.mmode <= {NUM_MODULES{MOD_MODE_RST}};
      st.cnt   <= CNT_RST;
    end else begin
      st <= nxt;
    end
  end

  assign rdata_o = st.rdata;
  assign irq_o   = st.irq;

  snap_latch_a: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    (rd_i && addr_i == REG_CNT_LO) ##1 (rd_i && addr_i == REG_CNT_HI)
      |=> rdata_o == $past(st.cnt[15:8], 2))
    else $error("high byte read did not return the snapshot");

  snap_hold_a: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    (rd_i && addr_i == REG_CNT_HI) |=> rdata_o == $past(st.snap))
    else $error("high byte read ignored the snapshot");

  read_quiet_a: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    (rd_i && !tick) |=> st.cnt == $past(st.cnt))
    else $error("counter changed on a read");

  div12_gap_a: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    (tick && st.mode.timebase_select == TB_SYS_DIV12
     && !(wr_i && addr_i == REG_MODE)) |=> !tick [*8])
    else $error("sysclk/12 ticks too close");

  ovf_set_a: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    (tick && st.cnt == CNT_MAX)
      |=> st.mode.counter_overflow_flag && st.cnt == CNT_RST)
    else $error("wrap did not set overflow flag");

  ovf_hold_a: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    (st.mode.counter_overflow_flag && !(wr_i && addr_i == REG_MODE))
      |=> st.mode.counter_overflow_flag)
    else $error("overflow flag cleared without a write");

  irq_gate_a: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    irq_o |-> $past(global_irq_enable_i) && $past(st.arr_ie))
    else $error("interrupt without both enables");

  idle_run_a: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    (cpu_idle_i && !st.mode.idle_suspend && st.run
     && st.mode.timebase_select == TB_SYS) |=> st.cnt != $past(st.cnt))
    else $error("counter stalled in idle without suspend");

  idle_halt_a: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    (cpu_idle_i && st.mode.idle_suspend && !wr_i)
      |=> st.cnt == $past(st.cnt))
    else $error("counter advanced during suspended idle");

  flag_keep_a: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    !(wr_i && addr_i == REG_CTRL)
      |=> (st.flags & $past(st.flags)) == $past(st.flags))
    else $error("module flag dropped without a write");

  cmp_clear_a: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    wr_lo[0] |=> !st.mmode[0].compare_enable ##1 1'b1)
    else $error("low value write kept compare enabled");

  wdt_lock_a: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    (st.mode.wdt_enable && wr_i && addr_i == REG_CNT_LO && !tick)
      |=> st.cnt == $past(st.cnt))
    else $error("counter written while watchdog enabled");

endmodule
`default_nettype wire

// ### cca_line_src.sv
// partner model: drives the six module capture lines
`timescale 1ns/1ps
`default_nettype none
module cca_line_src (
  input  wire logic  ref_clk_i,
  output logic [5:0] line_o
);
  initial line_o = '0;
  // every level is held 3 clocks, above the 2-clock minimum
  task automatic drive(input int n, input logic v);
    @(posedge ref_clk_i) line_o[n] <= v;
    repeat (3) @(posedge ref_clk_i);
  endtask
endmodule
`default_nettype wire

// ### counter_array_capture_compare_test.sv
// self-checking bench of the counter array
`timescale 1ns/1ps
`default_nettype none
module counter_array_capture_compare_test import cca_pkg::*; ();
  logic        ref_clk_i = 0, srst_i = 1, wr_i = 0, rd_i = 0;
  logic        idle = 0, gie = 0, irq;
  logic [7:0]  addr_i = '0, wdata_i = '0, rdata_o, d;
  logic [5:0]  line, lo, oe;
  logic [31:0] seed = 32'hfcdd3380, v;
  logic [15:0] mval = '0;
  logic [7:0]  codes [3] = '{8'h20, 8'h10, 8'h30};
  int          num_errors = 0, check_count = 0, cyc = 0, k = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  // oscillator and timer sources stay idle: timebase is system clock here
  cca_top DUT (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .cpu_idle_i(idle), .global_irq_enable_i(gie), .timer0_ovf_i(1'b0),
    .external_count_input_i(1'b0), .ext_osc_i(1'b0), .rtc_osc_i(1'b0),
    .module_io_line_i(line), .module_io_line_o(lo),
    .module_io_line_oe_o(oe), .irq_o(irq));
  cca_line_src src (.ref_clk_i(ref_clk_i), .line_o(line));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    @(posedge ref_clk_i);
    wr_i <= 1;
    addr_i <= a;
    wdata_i <= x;
    @(posedge ref_clk_i);
    wr_i <= 0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] x);
    @(posedge ref_clk_i);
    rd_i <= 1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i <= 0;
    #1 x = rdata_o;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a, d);
    chk(d, e);
  endtask
  task automatic setc(input logic [15:0] x);
    wr(REG_CNT_LO, x[7:0]);
    wr(REG_CNT_HI, x[15:8]);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 8000) begin
      num_errors++;
      end_sim();
    end
  end
  initial begin
    repeat (2) @(posedge ref_clk_i);
    srst_i <= 0;
    rc(REG_MODE, 8'h40);
    wr(REG_CNT_LO, 8'h55);
    wr(REG_MODE, 8'h00);
    wr(REG_MODE, 8'h09);
    setc(16'hfffe);
    rc(REG_CNT_LO, 8'hfe);
    rc(REG_CNT_HI, 8'hff);
    wr(REG_IRQ_EN, 8'h01);
    gie <= 1;
    wr(REG_CTRL, 8'h7f);
    repeat (8) @(posedge ref_clk_i);
    wr(REG_CTRL, 8'h3f);
    rc(REG_MODE, 8'h29);
    chk(irq, 1'b1);
    gie <= 0;
    repeat (3) @(posedge ref_clk_i);
    chk(irq, 1'b0);
    wr(REG_MODE, 8'h89);
    $display("test overflow done");
    // counter moves 2 per read pair unless idle suspends it
    idle <= 1;
    wr(REG_CTRL, 8'h7f);
    rd(REG_CNT_LO, d);
    rc(REG_CNT_LO, d);
    idle <= 0;
    rd(REG_CNT_LO, d);
    rc(REG_CNT_LO, 8'(d + 8'h02));
    wr(REG_MODE, 8'h09);
    idle <= 1;
    rd(REG_CNT_LO, d);
    rc(REG_CNT_LO, 8'(d + 8'h02));
    idle <= 0;
    gie <= 1;
    wr(REG_CTRL, 8'h00);
    $display("test idle done");
    setc(16'h0000);
    wr(8'h08, 8'h49);
    wr(8'h10, 8'h20);
    rc(8'h08, 8'h09);
    wr(8'h11, 8'h00);
    rc(8'h08, 8'h49);
    wr(REG_CTRL, 8'h7f);
    repeat (40) @(posedge ref_clk_i);
    wr(REG_CTRL, 8'h3f);
    rc(REG_CTRL, 8'h01);
    chk(irq, 1'b1);
    wr(8'h08, 8'h00);
    wr(REG_CTRL, 8'h00);
    $display("test timer done");
    // module 1 in each capture mode, stopped counter at random values
    for (int i = 0; i < 3; i++) begin
      wr(8'h09, codes[i]);
      for (int e = 1; e >= 0; e--) begin
        v = rnd();
        setc(v[15:0]);
        if (codes[i][4+e])
          mval = v[15:0];
        src.drive(1, e[0]);
        repeat (6) @(posedge ref_clk_i);
      end
      rc(8'h12, mval[7:0]);
      rc(8'h13, mval[15:8]);
      rc(REG_CTRL, 8'h02);
      wr(REG_CTRL, 8'h00);
    end
    rc(8'h10, 8'h20);
    $display("test capture done");
    setc(16'h0000);
    wr(8'h0a, 8'h4c);
    wr(8'h14, 8'h04);
    wr(8'h15, 8'h00);
    // mode reaches the line enable two edges after the write
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk({oe[2], lo[2]}, 2'b11);
    // module 3 in frequency output: low 2, step 3
    wr(8'h0b, 8'h46);
    wr(8'h16, 8'h02);
    wr(8'h17, 8'h03);
    wr(REG_CTRL, 8'h40);
    repeat (20) @(posedge ref_clk_i);
    wr(REG_CTRL, 8'h00);
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk({oe[2], lo[2]}, 2'b10);
    // model: one step per counter value 2, 5, 8 ... up to the stop value
    rd(REG_CNT_LO, d);
    k = (d >= 8'h02) ? (int'(d) - 2) / 3 + 1 : 0;
    rc(8'h16, 8'(2 + 3 * k));
    chk({oe[3], lo[3]}, {1'b1, 1'b1 ^ k[0]});
    // re-entering high-speed output sets the toggle state again
    wr(8'h14, 8'h04);
    wr(8'h15, 8'h00);
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk({oe[2], lo[2]}, 2'b11);
    $display("test output done");
    end_sim();
  end
endmodule
`default_nettype wire
